// [trb_pkg.sv]
// Shared constants, carrier structs and state records for the random byte generator
package trb_pkg;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [7:0] TRB_CTL_ADDR  = 8'hD6;
	localparam logic [7:0] TRB_DAT_ADDR  = 8'hD7;
	localparam logic [7:0] TRB_CTL_RESET = 8'h40;
	localparam logic [7:0] TRB_DAT_RESET = 8'h00;
	localparam int         TRB_PWR_BIT   = 7;
	localparam int         TRB_BIAS_BIT  = 6;
	localparam int         TRB_RDY_BIT   = 5;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int TRB_CLK_MHZ   = 20;
	localparam int TRB_GAP_NS    = 100000;
	localparam int TRB_START_NS  = 250000;
	// Least times, so both round up to whole cycles
	localparam int TRB_GAP_CYC   = (TRB_GAP_NS * TRB_CLK_MHZ + 999) / 1000;
	localparam int TRB_START_CYC = (TRB_START_NS * TRB_CLK_MHZ + 999) / 1000;

	// ----------------------------------------
	// Carriers
	// ----------------------------------------
	typedef struct packed {
		logic [7:0] addr;
		logic       wr;
		logic       rd;
		logic [7:0] wdata;
	} trb_sfr_req_t;

	typedef struct packed {
		logic bit_val;
		logic valid;
	} trb_noise_t;

	// ----------------------------------------
	// State records
	// ----------------------------------------
	typedef struct packed {
		logic have_first;
		logic first;
	} trb_corr_st_t;

	typedef struct packed {
		logic [7:0] shreg;
		logic [2:0] cnt;
		logic       full;
	} trb_pack_st_t;

	typedef struct packed {
		logic [1:0]  bit_sync;
		logic [1:0]  vld_sync;
		logic        vld_d;
		logic        pwr;
		logic        bias;
		logic        rdy;
		logic [7:0]  data;
		logic [7:0]  rdata;
		logic [15:0] start_cnt;
		logic [15:0] gap_cnt;
	} trb_main_st_t;

endpackage

// [trb_bias_fix.sv]
// Pairwise bias corrector with bypass for the raw noise bit stream
`timescale 1ns/1ps
module trb_bias_fix
	import trb_pkg::*;
(
	input  wire logic ref_clk_i,
	input  wire logic rst_i,
	input  wire logic clear_i,
	input  wire logic enable_i,
	input  wire logic in_bit_i,
	input  wire logic in_vld_i,
	output logic      out_bit_o,
	output logic      out_vld_o
);

	trb_corr_st_t st_r;
	trb_corr_st_t st_nxt;

	// ----------------------------------------
	// Pair logic
	// ----------------------------------------
	// Unequal pairs give the first bit, equal pairs are dropped; this
	// costs about four raw bits per output bit, hence the slower rate
	always_comb begin
		st_nxt    = st_r;
		out_bit_o = in_bit_i;
		out_vld_o = 1'b0;
		if (clear_i || !enable_i) begin
			st_nxt.have_first = 1'b0;
			out_vld_o         = in_vld_i && !clear_i;
		end else if (in_vld_i) begin
			if (!st_r.have_first) begin
				st_nxt.have_first = 1'b1;
				st_nxt.first      = in_bit_i;
			end else begin
				st_nxt.have_first = 1'b0;
				out_bit_o         = st_r.first;
				out_vld_o         = st_r.first != in_bit_i;
			end
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	a_pair_differs: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(enable_i && out_vld_o) |-> (st_r.have_first && in_bit_i == !st_r.first))
		else $error("corrector emitted a bit from an equal pair");

	a_bypass_pass: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(!enable_i && !clear_i && in_vld_i) |-> (out_vld_o && out_bit_o == in_bit_i))
		else $error("bypass did not pass the raw bit");

endmodule

// [trb_shift_pack.sv]
// Serial to parallel packer that gathers eight bits from the corrector, or from its bypass, into a byte
`timescale 1ns/1ps
module trb_shift_pack
	import trb_pkg::*;
(
	input  wire logic       ref_clk_i,
	input  wire logic       rst_i,
	input  wire logic       clear_i,
	input  wire logic       bit_i,
	input  wire logic       vld_i,
	input  wire logic       take_i,
	output logic [7:0]      byte_o,
	output logic            full_o
);

	trb_pack_st_t st_r;
	trb_pack_st_t st_nxt;

	// ----------------------------------------
	// Shift and hold
	// ----------------------------------------
	// Bits arriving while a byte waits are dropped: noise has no value to lose
	always_comb begin
		st_nxt = st_r;
		if (clear_i) begin
			st_nxt = '0;
		end else if (take_i) begin
			st_nxt.full = 1'b0;
			st_nxt.cnt  = 3'h0;
		end else if (vld_i && !st_r.full) begin
			st_nxt.shreg = {st_r.shreg[6:0], bit_i};
			st_nxt.cnt   = st_r.cnt + 3'h1;
			st_nxt.full  = st_r.cnt == 3'h7;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign byte_o = st_r.shreg;
	assign full_o = st_r.full;

	a_eighth_fills: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(!clear_i && !take_i && vld_i && !st_r.full && st_r.cnt == 3'h7)
		|=> (full_o && byte_o[0] == $past(bit_i)))
		else $error("eighth bit did not complete the byte");

endmodule

// [trb_true_random_byte.sv]
// Top of the random byte generator: register file, start-up and rate timing, readout
//
// Notes on behaviour
// - A finished byte in the data register sets the byte-ready flag.
// - Reading the data register clears the flag until the next new byte.
// - The interrupt is raised for every new byte.
// - The interrupt sets and clears exactly like the byte-ready flag.
// - Power bit going 0 to 1 clears stored byte and flag.
// - Raw bits pass a bias corrector before packing.
// - Clearing the bias enable bypasses the corrector for faster raw packing.
// - Bits shift serially into eight bits, read out in parallel.
// - Byte time varies with the noise, more so with correction on.
// - About 0.1 ms per byte raw, four times longer corrected.
// - First byte waits an extra 0.25 ms start-up after power-up.
// - Generation continues while the processor is in standby.
// - Output rate stays at or below about ten kilobytes per second.
// - Control register resets to 0x40: power bit 7, bias 6, ready 5.
// - Data register is read-only, eight bits, resets to 0x00.
`timescale 1ns/1ps
module trb_true_random_byte
	import trb_pkg::*;
#(
	parameter int STARTUP_CYC = TRB_START_CYC,
	parameter int GAP_CYC     = TRB_GAP_CYC
) (
	input  wire logic         ref_clk_i,
	input  wire logic         rst_i,
	input  wire trb_sfr_req_t sfr_req_i,
	input  wire trb_noise_t   noise_i,
	output logic [7:0]        sfr_rdata_o,
	output logic              random_byte_irq_o,
	output logic              noise_en_o
);

	trb_main_st_t st_r;
	trb_main_st_t st_nxt;

	logic       noise_stb;
	logic       starting;
	logic       corr_clear;
	logic       fix_bit;
	logic       fix_vld;
	logic [7:0] pack_byte;
	logic       pack_full;
	logic       commit;
	logic       ctl_wr;
	logic       pwr_rise;
	logic       dat_rd;

	// ----------------------------------------
	// Register access decode
	// ----------------------------------------
	assign ctl_wr   = sfr_req_i.wr && sfr_req_i.addr == TRB_CTL_ADDR;
	assign pwr_rise = ctl_wr && sfr_req_i.wdata[TRB_PWR_BIT] && !st_r.pwr;
	assign dat_rd   = sfr_req_i.rd && sfr_req_i.addr == TRB_DAT_ADDR;

	// ----------------------------------------
	// Noise intake
	// ----------------------------------------
	// One accepted bit per rising edge of the synchronised strobe
	assign noise_stb  = st_r.vld_sync[1] && !st_r.vld_d;
	assign starting   = st_r.start_cnt != 16'h0000;
	// Held clear while off or warming up, so no stale bit reaches a byte
	assign corr_clear = !st_r.pwr || pwr_rise || starting;

	trb_bias_fix u_fix (
		.ref_clk_i (ref_clk_i),
		.rst_i     (rst_i),
		.clear_i   (corr_clear),
		.enable_i  (st_r.bias),
		.in_bit_i  (st_r.bit_sync[1]),
		.in_vld_i  (noise_stb),
		.out_bit_o (fix_bit),
		.out_vld_o (fix_vld)
	);

	trb_shift_pack u_pack (
		.ref_clk_i (ref_clk_i),
		.rst_i     (rst_i),
		.clear_i   (corr_clear),
		.bit_i     (fix_bit),
		.vld_i     (fix_vld),
		.take_i    (commit),
		.byte_o    (pack_byte),
		.full_o    (pack_full)
	);

	// A byte is published only once the rate gap has run out, which caps
	// the output at one byte per 0.1 ms however fast the noise arrives
	assign commit = pack_full && !corr_clear && st_r.gap_cnt == 16'h0000;

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		st_nxt          = st_r;
		st_nxt.bit_sync = {st_r.bit_sync[0], noise_i.bit_val};
		st_nxt.vld_sync = {st_r.vld_sync[0], noise_i.valid};
		st_nxt.vld_d    = st_r.vld_sync[1];

		if (ctl_wr) begin
			st_nxt.pwr  = sfr_req_i.wdata[TRB_PWR_BIT];
			st_nxt.bias = sfr_req_i.wdata[TRB_BIAS_BIT];
		end

		// Start-up wait counts only while powered
		if (pwr_rise) begin
			st_nxt.start_cnt = 16'(STARTUP_CYC);
		end else if (!st_r.pwr) begin
			st_nxt.start_cnt = 16'h0000;
		end else if (starting) begin
			st_nxt.start_cnt = st_r.start_cnt - 16'h0001;
		end

		if (pwr_rise) begin
			st_nxt.gap_cnt = 16'h0000;
		end else if (commit) begin
			st_nxt.gap_cnt = 16'(GAP_CYC - 1);
		end else if (st_r.gap_cnt != 16'h0000) begin
			st_nxt.gap_cnt = st_r.gap_cnt - 16'h0001;
		end

		// New byte wins over a read in the same cycle
		if (pwr_rise) begin
			st_nxt.data = TRB_DAT_RESET;
			st_nxt.rdy  = 1'b0;
		end else if (commit) begin
			st_nxt.data = pack_byte;
			st_nxt.rdy  = 1'b1;
		end else if (dat_rd) begin
			st_nxt.rdy  = 1'b0;
		end

		// Read data registered: valid the cycle after the read strobe
		if (sfr_req_i.rd && sfr_req_i.addr == TRB_CTL_ADDR) begin
			st_nxt.rdata = {st_r.pwr, st_r.bias, st_r.rdy, 5'h00};
		end else if (dat_rd) begin
			st_nxt.rdata = st_r.data;
		end else begin
			st_nxt.rdata = 8'h00;
		end
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	// No standby input exists: nothing here stops while the processor sleeps
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			st_r      <= '0;
			st_r.pwr  <= TRB_CTL_RESET[TRB_PWR_BIT];
			st_r.bias <= TRB_CTL_RESET[TRB_BIAS_BIT];
			st_r.rdy  <= TRB_CTL_RESET[TRB_RDY_BIT];
			st_r.data <= TRB_DAT_RESET;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign sfr_rdata_o       = st_r.rdata;
	assign random_byte_irq_o = st_r.rdy;
	assign noise_en_o        = st_r.pwr;

	// ----------------------------------------
	// Checking aids
	// ----------------------------------------
	logic [15:0] since_commit_r;
	logic [15:0] since_rise_r;

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			since_commit_r <= 16'hFFFF;
			since_rise_r   <= 16'h0000;
		end else begin
			if (commit) begin
				since_commit_r <= 16'h0000;
			end else if (since_commit_r != 16'hFFFF) begin
				since_commit_r <= since_commit_r + 16'h0001;
			end
			if (pwr_rise) begin
				since_rise_r <= 16'h0000;
			end else if (since_rise_r != 16'hFFFF) begin
				since_rise_r <= since_rise_r + 16'h0001;
			end
		end
	end

	a_rise_clears: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		pwr_rise |=> (!st_r.rdy && st_r.data == 8'h00 && !random_byte_irq_o))
		else $error("power-up did not clear byte and flag");

	a_read_clears: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(dat_rd && !commit && !pwr_rise) |=> (!st_r.rdy && sfr_rdata_o == $past(st_r.data)))
		else $error("data read did not clear flag or return the byte");

	a_commit_sets: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		commit |=> (st_r.rdy && st_r.data == $past(pack_byte)))
		else $error("new byte not stored with flag set");

	a_irq_cause: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		$rose(random_byte_irq_o) |-> $past(commit))
		else $error("interrupt rose without a new byte");

	a_rate_gap: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		commit |-> (since_commit_r >= 16'(GAP_CYC - 1)))
		else $error("bytes closer than the rate limit");

	a_startup_wait: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		commit |-> (since_rise_r >= 16'(STARTUP_CYC)))
		else $error("byte before start-up delay elapsed");

	a_off_silent: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		!st_r.pwr |-> (!commit && !fix_vld))
		else $error("generator active while powered down");

	a_ctl_reset: assert property (@(posedge ref_clk_i)
		$past(rst_i) |-> (!st_r.pwr && st_r.bias && !st_r.rdy && st_r.data == 8'h00))
		else $error("control or data reset value wrong");

	a_ctl_read: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(sfr_req_i.rd && sfr_req_i.addr == TRB_CTL_ADDR)
		|=> (sfr_rdata_o[4:0] == 5'h00 && sfr_rdata_o[7] == $past(st_r.pwr)))
		else $error("control read returned wrong bits");

	// ----------------------------------------
	// Register and intake checks
	// ----------------------------------------
	// Read data stands one cycle only, so anything else must read as zero
	a_rdata_idle: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		!sfr_req_i.rd |=> (sfr_rdata_o == 8'h00))
		else $error("read data not zero outside a read");

	a_unmapped_read: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(sfr_req_i.rd && sfr_req_i.addr != TRB_CTL_ADDR && sfr_req_i.addr != TRB_DAT_ADDR)
		|=> (sfr_rdata_o == 8'h00))
		else $error("unmapped address returned data");

	a_dat_read_value: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		dat_rd |=> (sfr_rdata_o == $past(st_r.data)))
		else $error("data read returned wrong byte");

	a_ctl_read_bits: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(sfr_req_i.rd && sfr_req_i.addr == TRB_CTL_ADDR)
		|=> (sfr_rdata_o[6:5] == {$past(st_r.bias), $past(st_r.rdy)}))
		else $error("control read lost bias or ready bit");

	a_pwr_write: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		ctl_wr |=> (noise_en_o == $past(sfr_req_i.wdata[TRB_PWR_BIT])))
		else $error("power bit write not applied");

	a_bias_write: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		ctl_wr |=> (st_r.bias == $past(sfr_req_i.wdata[TRB_BIAS_BIT])))
		else $error("bias enable write not applied");

	a_ctl_hold: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		!ctl_wr |=> ($stable(st_r.pwr) && $stable(st_r.bias)))
		else $error("control bits changed without a write");

	a_dat_no_write: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(sfr_req_i.wr && sfr_req_i.addr == TRB_DAT_ADDR && !commit)
		|=> $stable(st_r.data))
		else $error("write reached the read-only data register");

	// Ready and byte move only on a new byte, a data read or a power-up
	a_rdy_hold: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(!commit && !dat_rd && !pwr_rise) |=> $stable(st_r.rdy))
		else $error("ready flag changed with no cause");

	a_data_hold: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(!commit && !pwr_rise) |=> $stable(st_r.data))
		else $error("stored byte changed with no cause");

	a_irq_new_byte: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		commit |=> random_byte_irq_o)
		else $error("no interrupt for a new byte");

	a_irq_read_drop: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(dat_rd && !commit && !pwr_rise) |=> !random_byte_irq_o)
		else $error("interrupt stayed up after the byte was read");

	a_irq_write_keep: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(sfr_req_i.wr && !sfr_req_i.rd && !pwr_rise && !commit)
		|=> (random_byte_irq_o == $past(random_byte_irq_o)))
		else $error("interrupt changed on a plain write");

	a_start_no_bits: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(st_r.pwr && starting) |-> !fix_vld)
		else $error("bit accepted during start-up wait");

	a_stb_single: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		noise_stb |=> !noise_stb)
		else $error("one strobe edge accepted twice");

	a_stb_source: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		noise_stb |-> $past(noise_i.valid, 2))
		else $error("bit accepted without a strobe");

	a_bypass_bit: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(!st_r.bias && !corr_clear && noise_stb)
		|-> (fix_vld && fix_bit == $past(noise_i.bit_val, 2)))
		else $error("raw bit not passed in bypass");

endmodule

// [trb_noise_model.sv]
// Behavioural noise source that feeds one bit per strobe while powered
`timescale 1ns/1ps
module trb_noise_model
	import trb_pkg::*;
(
	input  wire logic       ref_clk_i,
	input  wire logic       en_i,
	input  wire logic [1:0] mode_i,
	output trb_noise_t      noise_o
);
	int ph = 0;

	initial noise_o = '0;

	// Strobe high three cycles, low two; the bit moves one cycle before each rise
	always @(posedge ref_clk_i) begin
		ph <= (ph == 4) ? 0 : ph + 1;
		noise_o.valid <= en_i && ph < 3;
		if (ph == 4) begin
			noise_o.bit_val <= (mode_i == 2'h0) ? 1'($urandom) : (mode_i == 2'h1) ? 1'b1 : ~noise_o.bit_val;
		end
	end
endmodule

// [trb_true_random_byte_test.sv]
// Self-checking bench for the random byte generator
`timescale 1ns/1ps
module trb_true_random_byte_test;
	import trb_pkg::*;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	// Shortened counts keep the run brief; the gap is long enough to bind
	localparam int SU = 20;
	localparam int GP = 60;
	logic         ref_clk_i = 1'b0;
	logic         rst_i     = 1'b1;
	trb_sfr_req_t sfr_req_i = '0;
	trb_noise_t   noise_i;
	logic [7:0]   sfr_rdata_o;
	logic         irq_o;
	logic         noise_en_o;
	logic [1:0]   mode      = 2'h1;
	logic [7:0]   rd_v;
	logic [7:0]   r;
	int           n_fail = 0;
	int           samples_checked = 0;
	int           cyc = 0;
	int           k;

	trb_true_random_byte #(.STARTUP_CYC(SU), .GAP_CYC(GP)) u_trb_true_random_byte (
		.ref_clk_i        (ref_clk_i),
		.rst_i            (rst_i),
		.sfr_req_i        (sfr_req_i),
		.noise_i          (noise_i),
		.sfr_rdata_o      (sfr_rdata_o),
		.random_byte_irq_o(irq_o),
		.noise_en_o       (noise_en_o)
	);

	trb_noise_model u_trb_noise_model (
		.ref_clk_i(ref_clk_i),
		.en_i     (noise_en_o),
		.mode_i   (mode),
		.noise_o  (noise_i)
	);

	// ----------------------------------------
	// Clock and watchdog
	// ----------------------------------------
	always #25 ref_clk_i = ~ref_clk_i;

	always @(posedge ref_clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_fail++;
			end_of_test();
		end
	end

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One access; read data lands the cycle after the strobe edge
	task automatic sfr(input logic [7:0] a, input logic w, input logic [7:0] d);
		@(posedge ref_clk_i) sfr_req_i <= {a, w, ~w, d};
		@(posedge ref_clk_i) sfr_req_i <= '0;
		#1 rd_v = sfr_rdata_o;
	endtask

	task automatic wait_irq(input int lim);
		k = 0;
		while (irq_o !== 1'b1 && k < lim) begin
			@(posedge ref_clk_i) #1 k++;
		end
	endtask

	task automatic end_of_test();
		$display("checked=%0d failed=%0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		void'($urandom(61));
		repeat (8) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		sfr(TRB_CTL_ADDR, 1'b0, 8'h00);
		chk(rd_v, TRB_CTL_RESET);
		sfr(TRB_DAT_ADDR, 1'b0, 8'h00);
		chk(rd_v, TRB_DAT_RESET);
		chk({7'h0, noise_en_o}, 8'h00);
		r = 8'($urandom_range(0, 213));
		sfr(r, 1'b1, 8'hFF);
		sfr(r, 1'b0, 8'h00);
		chk(rd_v, 8'h00);
		sfr(TRB_DAT_ADDR, 1'b1, 8'h5A);
		sfr(TRB_DAT_ADDR, 1'b0, 8'h00);
		chk(rd_v, 8'h00);
		// Power up raw with random junk in the unused and flag bits
		r = 8'($urandom);
		sfr(TRB_CTL_ADDR, 1'b1, {2'b10, r[5:0]});
		wait_irq(400);
		chk({7'h0, k >= SU + 1 && k < 400}, 8'h01);
		chk({7'h0, noise_en_o}, 8'h01);
		sfr(TRB_CTL_ADDR, 1'b0, 8'h00);
		chk(rd_v, 8'hA0);
		sfr(TRB_DAT_ADDR, 1'b0, 8'h00);
		chk(rd_v, 8'hFF);
		chk({7'h0, irq_o}, 8'h00);
		wait_irq(400);
		chk({7'h0, k + 4 >= GP && k < 400}, 8'h01);
		// Power cycle with a byte still unread
		sfr(TRB_CTL_ADDR, 1'b1, 8'h00);
		sfr(TRB_CTL_ADDR, 1'b1, 8'h80);
		sfr(TRB_DAT_ADDR, 1'b0, 8'h00);
		chk(rd_v, 8'h00);
		sfr(TRB_CTL_ADDR, 1'b0, 8'h00);
		chk(rd_v, 8'h80);
		mode = 2'h0;
		for (int i = 0; i < 6; i++) begin
			wait_irq(400);
			chk({7'h0, irq_o}, 8'h01);
			repeat ($urandom_range(0, 30)) @(posedge ref_clk_i);
			sfr(TRB_DAT_ADDR, 1'b0, 8'h00);
			chk({7'h0, irq_o}, 8'h00);
			sfr(TRB_CTL_ADDR, 1'b0, 8'h00);
			chk(rd_v, 8'h80);
		end
		// Corrector on: a constant stream must never yield a byte
		sfr(TRB_CTL_ADDR, 1'b1, 8'h00);
		mode = 2'h1;
		sfr(TRB_CTL_ADDR, 1'b1, 8'hC0);
		wait_irq(400);
		chk({7'h0, irq_o}, 8'h00);
		mode = 2'h2;
		wait_irq(800);
		chk({7'h0, irq_o}, 8'h01);
		sfr(TRB_DAT_ADDR, 1'b0, 8'h00);
		chk({7'h0, rd_v == 8'h00 || rd_v == 8'hFF}, 8'h01);
		sfr(TRB_CTL_ADDR, 1'b0, 8'h00);
		chk(rd_v, 8'hC0);
		end_of_test();
	end
endmodule
